// *** design/bsa_send_ctrl.sv ***
// transmit-side send area controller: buffer fill, framing, reply wait, completion
`timescale 1ns/100ps
`include "bsa_consts.svh"
module bsa_send_ctrl (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cfg_load_i,
  input wire bsa_pkg::bsa_area_s cfg_ch1_i,
  input wire bsa_pkg::bsa_area_s cfg_ch2_i,
  input wire logic cfg_sum_en_i,
  input wire logic send_message_request_i,
  input wire bsa_pkg::bsa_req_s req_i,
  input wire logic [15:0] msg_word_i,
  input wire logic msg_valid_i,
  output logic msg_ready_o,
  output logic buf_we_o,
  output logic [15:0] buf_addr_o,
  output logic [15:0] buf_wdata_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic reply_valid_i,
  input wire logic reply_nak_i,
  input wire logic [15:0] reply_code_i,
  output logic busy_o,
  output logic cfg_error_o,
  output logic send_done_flag_o,
  output logic abnormal_done_o,
  output logic [15:0] completion_status_word_o
);
  bsa_pkg::bsa_state_e state;
  bsa_pkg::bsa_area_s area_ch1, area_ch2, area;
  logic sum_en, err, accept, too_long, tx_acc, byte_state, take;
  logic [16:0] bytes_left;
  logic [15:0] widx, word, count, err_code, need_words;
  logic [7:0] sum, cur_byte;
  bsa_pkg::bsa_area_s sel_area;

  function automatic logic area_ok(input bsa_pkg::bsa_area_s a);
    logic [16:0] last;
    last = {1'b0, a.base} + {1'b0, a.len} - 17'h00001;
    area_ok = (a.len >= `BSA_LEN_MIN) && (a.len <= `BSA_LEN_MAX) && // R03
      (({1'b0, a.base} >= `BSA_USR1_LO && last <= `BSA_USR1_HI) || // R02
       ({1'b0, a.base} >= `BSA_USR2_LO && last <= `BSA_USR2_HI));
  endfunction : area_ok

  // each channel is checked alone: a rejected area keeps its previous value while the other channel and sum_en still load
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      area_ch1 <= '{base: `BSA_CH1_BASE, len: `BSA_CH1_LEN}; // R01
      area_ch2 <= '{base: `BSA_CH2_BASE, len: `BSA_CH2_LEN}; // R01
      sum_en <= 1'b0;
      cfg_error_o <= 1'b0;
    end else if (cfg_load_i && state == bsa_pkg::ST_IDLE) begin
      if (area_ok(cfg_ch1_i)) area_ch1 <= cfg_ch1_i; // R14
      if (area_ok(cfg_ch2_i)) area_ch2 <= cfg_ch2_i; // R14
      sum_en <= cfg_sum_en_i; // R14
      cfg_error_o <= !area_ok(cfg_ch1_i) || !area_ok(cfg_ch2_i);
    end
  end

  assign sel_area = req_i.channel_two ? area_ch2 : area_ch1; // R07
  assign need_words = req_i.byte_unit ? 16'((17'(req_i.count) + 17'h00001) >> 1)
                                      : req_i.count; // R09
  assign too_long = need_words > (sel_area.len - 16'h0001); // R05
  assign accept = send_message_request_i && state == bsa_pkg::ST_IDLE; // R17
  assign tx_acc = tx_valid_o && tx_ready_i;
  assign take = msg_ready_o && msg_valid_i;
  assign byte_state = state inside {bsa_pkg::ST_ENQ, bsa_pkg::ST_CNT_LO, bsa_pkg::ST_CNT_HI,
                                    bsa_pkg::ST_DAT_LO, bsa_pkg::ST_DAT_HI, bsa_pkg::ST_SUM};

  always_comb begin
    unique case (state)
      bsa_pkg::ST_ENQ: cur_byte = `BSA_ENQ; // R15
      bsa_pkg::ST_CNT_LO: cur_byte = count[7:0];
      bsa_pkg::ST_CNT_HI: cur_byte = count[15:8];
      bsa_pkg::ST_DAT_LO: cur_byte = word[7:0]; // R18
      bsa_pkg::ST_DAT_HI: cur_byte = word[15:8];
      bsa_pkg::ST_SUM: cur_byte = sum; // R15
      default: cur_byte = 8'h00;
    endcase
  end

  // sequencing; data is streamed to the line as it is stored, with only the current word held locally in word
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= bsa_pkg::ST_IDLE;
      area <= '0;
      count <= 16'h0000;
      bytes_left <= 17'h00000;
      widx <= 16'h0000;
      word <= 16'h0000;
      err <= 1'b0;
      err_code <= `BSA_STATUS_OK;
      busy_o <= 1'b0;
    end else begin
      unique case (state)
        bsa_pkg::ST_IDLE: if (accept) begin
          area <= sel_area;
          count <= req_i.count;
          bytes_left <= req_i.byte_unit ? 17'(req_i.count) : {req_i.count, 1'b0};
          widx <= 16'h0000;
          busy_o <= 1'b1;
          err <= too_long; // R05
          err_code <= too_long ? `BSA_ERR_TOO_LONG : `BSA_STATUS_OK;
          state <= too_long ? bsa_pkg::ST_DONE : bsa_pkg::ST_ENQ; // R06
        end
        bsa_pkg::ST_ENQ: if (tx_acc) state <= bsa_pkg::ST_CNT_LO;
        bsa_pkg::ST_CNT_LO: if (tx_acc) state <= bsa_pkg::ST_CNT_HI;
        bsa_pkg::ST_CNT_HI: if (tx_acc) begin
          if (bytes_left == 17'h00000)
            state <= sum_en ? bsa_pkg::ST_SUM : bsa_pkg::ST_WAIT;
          else
            state <= bsa_pkg::ST_FETCH;
        end
        bsa_pkg::ST_FETCH: if (take) begin
          word <= msg_word_i;
          widx <= widx + 16'h0001;
          state <= bsa_pkg::ST_DAT_LO;
        end
        bsa_pkg::ST_DAT_LO, bsa_pkg::ST_DAT_HI: if (tx_acc) begin
          bytes_left <= bytes_left - 17'h00001;
          if (bytes_left == 17'h00001)
            state <= sum_en ? bsa_pkg::ST_SUM : bsa_pkg::ST_WAIT; // R15
          else
            state <= (state == bsa_pkg::ST_DAT_LO) ? bsa_pkg::ST_DAT_HI : bsa_pkg::ST_FETCH;
        end
        bsa_pkg::ST_SUM: if (tx_acc) state <= bsa_pkg::ST_WAIT;
        bsa_pkg::ST_WAIT: if (reply_valid_i) begin // R10
          err <= reply_nak_i; // R12
          err_code <= reply_nak_i ? reply_code_i : `BSA_STATUS_OK; // R12
          state <= bsa_pkg::ST_DONE; // R11
        end
        bsa_pkg::ST_DONE: begin
          busy_o <= 1'b0;
          state <= bsa_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // sum covers count and data bytes, not the leading control code
  always_ff @(posedge mclk_i) begin
    if (rst_i || accept) sum <= 8'h00;
    else if (tx_acc && state != bsa_pkg::ST_ENQ && state != bsa_pkg::ST_SUM)
      sum <= sum + tx_data_o; // R15
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (tx_valid_o) begin
      if (tx_ready_i) tx_valid_o <= 1'b0;
    end else if (byte_state) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= cur_byte;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) msg_ready_o <= 1'b0;
    else if (take) msg_ready_o <= 1'b0;
    else msg_ready_o <= state == bsa_pkg::ST_FETCH;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      buf_we_o <= 1'b0;
      buf_addr_o <= 16'h0000;
      buf_wdata_o <= 16'h0000;
    end else if (accept && !too_long) begin
      buf_we_o <= 1'b1; // R16
      buf_addr_o <= sel_area.base; // R18
      buf_wdata_o <= req_i.count;
    end else if (take) begin
      buf_we_o <= 1'b1; // R16
      buf_addr_o <= area.base + widx + 16'h0001; // R18
      buf_wdata_o <= msg_word_i;
    end else begin
      buf_we_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      send_done_flag_o <= 1'b0;
      abnormal_done_o <= 1'b0;
      completion_status_word_o <= `BSA_STATUS_OK;
    end else begin
      send_done_flag_o <= state == bsa_pkg::ST_DONE; // R13
      abnormal_done_o <= state == bsa_pkg::ST_DONE && err; // R12
      if (accept) completion_status_word_o <= `BSA_STATUS_OK; // R19
      else if (state == bsa_pkg::ST_DONE) completion_status_word_o <= err_code; // R12
    end
  end

  done_one_scan_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
    send_done_flag_o |=> !send_done_flag_o) else $error("done flag longer than one scan");
  abnormal_with_done_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
    abnormal_done_o |-> send_done_flag_o) else $error("abnormal without done");
  enq_leads_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
    (state == bsa_pkg::ST_ENQ && tx_valid_o) |-> tx_data_o == `BSA_ENQ)
    else $error("frame does not open with ENQ");
  sum_only_enabled_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
    state == bsa_pkg::ST_SUM |-> sum_en) else $error("sum sent while disabled");
  count_word_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R18
    (accept && !too_long) |=> buf_we_o && buf_wdata_o == $past(req_i.count)
      && buf_addr_o == $past(sel_area.base)) else $error("count word not stored at base");
  nak_status_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
    (state == bsa_pkg::ST_WAIT && reply_valid_i && reply_nak_i) |-> ##2
      (abnormal_done_o && completion_status_word_o == $past(reply_code_i, 2)))
    else $error("nak not reported");
  ack_normal_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
    (state == bsa_pkg::ST_WAIT && reply_valid_i && !reply_nak_i) |-> ##2
      (send_done_flag_o && !abnormal_done_o && completion_status_word_o == `BSA_STATUS_OK))
    else $error("ack not reported as normal");
  quiet_in_progress_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R19
    (state inside {bsa_pkg::ST_ENQ, bsa_pkg::ST_FETCH, bsa_pkg::ST_WAIT}) |=>
      !send_done_flag_o && !abnormal_done_o) else $error("completion during send");
  default_area_a: assert property (@(posedge mclk_i) // R01
    rst_i |=> area_ch1.base == `BSA_CH1_BASE && area_ch2.base == `BSA_CH2_BASE)
    else $error("default area wrong");
  area_legal_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R02
    area_ok(area_ch1) && area_ok(area_ch2)) else $error("area outside user region");
endmodule : bsa_send_ctrl

// *** design/bsa_consts.svh ***
// constants for the bidirectional send area controller
// Behaviour
// R01: default areas 400h-5FFh and 800h-9FFh
// R02: area start only inside user region
// R03: area length 0001h to 1A00h, in region
// R04: configurer avoids overlap with other functions
// R05: host keeps message within area data portion
// R06: host prepares data, then requests the send
// R07: host names the channel per request
// R08: host clears its result word first
// R09: count unit follows word/byte setting
// R10: after sending, wait for ack or nak
// R11: on reply finish and signal completion
// R12: nak also flags abnormal, stores error code
// R13: send done flag high one scan
// R14: take tool configuration when host starts
// R15: prefix ENQ, append sum check if enabled
// R16: write count and data into area
// R17: only one send outstanding at a time
// R18: count first word, data follows, low byte first
// R19: completion indications low while send in progress
`ifndef BSA_CONSTS_SVH
`define BSA_CONSTS_SVH
`define BSA_CH1_BASE 16'h0400
`define BSA_CH1_LEN 16'h0200
`define BSA_CH2_BASE 16'h0800
`define BSA_CH2_LEN 16'h0200
`define BSA_USR1_LO 17'h00400
`define BSA_USR1_HI 17'h01AFF
`define BSA_USR2_LO 17'h02600
`define BSA_USR2_HI 17'h03FFF
`define BSA_LEN_MIN 16'h0001
`define BSA_LEN_MAX 16'h1A00
`define BSA_ENQ 8'h05
`define BSA_ERR_TOO_LONG 16'h7F01
`define BSA_STATUS_OK 16'h0000
`endif

// *** design/bsa_pkg.sv ***
// types for the bidirectional send area controller
package bsa_pkg;
  typedef struct packed {
    logic [15:0] base;
    logic [15:0] len;
  } bsa_area_s;
  typedef struct packed {
    logic channel_two;
    logic byte_unit;
    logic [15:0] count;
  } bsa_req_s;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ENQ, ST_CNT_LO, ST_CNT_HI, ST_FETCH, ST_DAT_LO, ST_DAT_HI,
    ST_SUM, ST_WAIT, ST_DONE
  } bsa_state_e;
endpackage : bsa_pkg

// *** testbench/bsa_partner.sv ***
// far-side serial device model: takes line bytes, then answers ack or nak
`timescale 1ns/100ps
module bsa_partner (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic tx_valid_i,
  input wire logic slow_i,
  input wire logic nak_i,
  input wire logic [15:0] code_i,
  input wire logic [15:0] nbytes_i,
  output logic tx_ready_o,
  output logic reply_valid_o,
  output logic reply_nak_o,
  output logic [15:0] reply_code_o
);
  logic [15:0] got;
  logic [1:0] lag;
  logic pend;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      {tx_ready_o, lag, got, pend, reply_valid_o, reply_nak_o, reply_code_o} <= '0;
    end else begin
      tx_ready_o <= tx_valid_i && !tx_ready_o && lag == 2'h0;
      lag <= (tx_valid_i && !tx_ready_o && lag != 2'h0) ? lag - 2'h1 : {slow_i, slow_i};
      pend <= tx_valid_i && tx_ready_o && got + 16'h0001 == nbytes_i;
      got <= pend ? 16'h0000 : got + {15'h0, tx_valid_i && tx_ready_o};
      reply_valid_o <= pend;
      // released reply lines show the inverse, not a stale value
      reply_nak_o <= pend ? nak_i : ~reply_nak_o;
      reply_code_o <= pend ? code_i : ~reply_code_o;
    end
  end
endmodule : bsa_partner

// *** testbench/bsa_send_ctrl_test.sv ***
// self-checking bench for the send area controller
`timescale 1ns/100ps
`include "bsa_consts.svh"
module bsa_send_ctrl_test;
  logic mclk_i = 0, rst_i = 1, cfg_load_i = 0, cfg_sum_en_i = 0, send_message_request_i = 0;
  logic msg_valid_i = 1, slow = 0, pnak = 0, sum_en = 0;
  bsa_pkg::bsa_area_s cfg_ch1_i = '0, cfg_ch2_i = '0;
  bsa_pkg::bsa_req_s req_i = '0;
  logic [15:0] msg_word_i = '0, pcode = '0, nbytes = '0;
  logic msg_ready_o, buf_we_o, tx_valid_o, tx_ready, reply_valid, reply_nak, busy_o;
  logic cfg_error_o, send_done_flag_o, abnormal_done_o;
  logic [15:0] buf_addr_o, buf_wdata_o, reply_code, completion_status_word_o;
  logic [7:0] tx_data_o;
  logic [31:0] rs = 32'h55975053;
  logic [31:0] exp_wr[$], exp_tx[$], exp_done[$];
  logic [15:0] words[64];
  int failures = 0, num_checks = 0, ndone = 0, widx = 0;
  initial forever #12.5 mclk_i = ~mclk_i;
  bsa_send_ctrl bsa_send_ctrl_i (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_load_i(cfg_load_i),
    .cfg_ch1_i(cfg_ch1_i), .cfg_ch2_i(cfg_ch2_i), .cfg_sum_en_i(cfg_sum_en_i),
    .send_message_request_i(send_message_request_i), .req_i(req_i), .msg_word_i(msg_word_i),
    .msg_valid_i(msg_valid_i), .msg_ready_o(msg_ready_o), .buf_we_o(buf_we_o),
    .buf_addr_o(buf_addr_o), .buf_wdata_o(buf_wdata_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready), .reply_valid_i(reply_valid),
    .reply_nak_i(reply_nak), .reply_code_i(reply_code), .busy_o(busy_o),
    .cfg_error_o(cfg_error_o), .send_done_flag_o(send_done_flag_o),
    .abnormal_done_o(abnormal_done_o), .completion_status_word_o(completion_status_word_o));
  bsa_partner bsa_partner_i (.mclk_i(mclk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o),
    .slow_i(slow), .nak_i(pnak), .code_i(pcode), .nbytes_i(nbytes), .tx_ready_o(tx_ready),
    .reply_valid_o(reply_valid), .reply_nak_o(reply_nak), .reply_code_o(reply_code));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // word feed changes only at the falling edge; index moves on each take
  // valid toggles when the seed bit is clear, so the word handshake also sees gaps
  always @(negedge mclk_i) begin
    msg_word_i = words[widx];
    msg_valid_i = rs[3] | ~msg_valid_i;
  end
  always @(posedge mclk_i) if (msg_valid_i && msg_ready_o === 1'b1) widx++;
  always @(posedge mclk_i) begin
    if (buf_we_o === 1'b1)
      chk("buffer", {buf_addr_o, buf_wdata_o}, exp_wr.size() ? exp_wr.pop_front() : 'x);
    if (tx_valid_o === 1'b1 && tx_ready === 1'b1)
      chk("line", {24'h0, tx_data_o}, exp_tx.size() ? exp_tx.pop_front() : 'x);
    if (send_done_flag_o === 1'b1) begin
      chk("done", {abnormal_done_o, completion_status_word_o},
        exp_done.size() ? exp_done.pop_front() : 'x);
      ndone++;
    end
  end
  task automatic cfg(input logic [31:0] a1, input logic [31:0] a2, input logic se,
      input logic err);
    @(negedge mclk_i);
    {cfg_ch1_i, cfg_ch2_i, cfg_sum_en_i, cfg_load_i} = {a1, a2, se, 1'b1};
    sum_en = se;
    @(negedge mclk_i);
    cfg_load_i = 0;
    chk("cfg error", {31'h0, cfg_error_o}, {31'h0, err});
  endtask : cfg
  task automatic send(input logic ch, input logic bu, input logic [15:0] cnt,
      input logic nk, input logic [15:0] cd, input logic [15:0] base, input logic [15:0] len);
    int nw, k, d0, nb;
    logic [7:0] sm;
    logic [15:0] w, ec, res;
    logic tl, odd;
    nw = bu ? (cnt + 1) / 2 : cnt;
    tl = nw > len - 1;
    odd = bu & cnt[0];
    nb = 3;
    sm = cnt[7:0] + cnt[15:8];
    if (!tl) begin
      exp_wr.push_back({base, cnt});
      exp_tx.push_back(`BSA_ENQ);
      exp_tx.push_back(cnt[7:0]);
      exp_tx.push_back(cnt[15:8]);
      for (k = 0; k < nw; k++) begin
        rs = xs(rs);
        w = rs[15:0];
        if (odd && k == nw - 1) w[15:8] = 8'h00;
        words[k] = w;
        exp_wr.push_back({base + 16'(k + 1), w});
        exp_tx.push_back(w[7:0]);
        sm = sm + w[7:0];
        nb++;
        if (!(odd && k == nw - 1)) begin
          exp_tx.push_back(w[15:8]);
          sm = sm + w[15:8];
          nb++;
        end
      end
      if (sum_en) exp_tx.push_back(sm);
      nb = nb + sum_en;
    end
    ec = tl ? `BSA_ERR_TOO_LONG : (nk ? cd : `BSA_STATUS_OK);
    exp_done.push_back({tl | nk, ec});
    rs = xs(rs);
    {slow, pnak, pcode, nbytes, widx} = {rs[0], nk, cd, tl ? 16'h0 : 16'(nb), 32'h0};
    res = 16'h0000;
    @(negedge mclk_i);
    {send_message_request_i, req_i} = {1'b1, ch, bu, cnt};
    @(negedge mclk_i);
    send_message_request_i = 0;
    chk("busy", {31'h0, busy_o}, 32'h1);
    d0 = ndone;
    for (k = 0; k < 3000 && ndone == d0; k++) @(negedge mclk_i);
    chk("done seen", ndone - d0, 32'h1);
    @(negedge mclk_i);
    chk("done width", {31'h0, send_done_flag_o}, 32'h0);
    chk("busy end", {31'h0, busy_o}, 32'h0);
    res = completion_status_word_o;
    chk("status held", {16'h0, res}, {16'h0, ec});
  endtask : send
  initial begin
    repeat (2000 * 25) @(posedge mclk_i);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_i = 0;
    send(0, 0, 16'h0003, 0, 16'h0, `BSA_CH1_BASE, `BSA_CH1_LEN);
    send(1, 1, 16'h0005, 1, 16'h1234, `BSA_CH2_BASE, `BSA_CH2_LEN);
    cfg({16'h2600, 16'h0004}, {16'h1B00, 16'h0010}, 1, 1);
    send(0, 0, 16'h0003, 0, 16'h0, 16'h2600, 16'h0004);
    send(0, 0, 16'h0004, 0, 16'h0, 16'h2600, 16'h0004);
    send(1, 1, 16'h0006, 0, 16'h0, `BSA_CH2_BASE, `BSA_CH2_LEN);
    cfg({16'h0400, 16'h1A00}, {16'h2604, 16'h19FC}, 0, 1);
    send(1, 0, 16'h0002, 1, 16'h00A5, 16'h2604, 16'h19FC);
    send(0, 1, 16'h0007, 0, 16'h0, 16'h2600, 16'h0004);
    chk("pending", exp_wr.size() + exp_tx.size() + exp_done.size(), 0);
    report_and_stop();
  end
endmodule : bsa_send_ctrl_test
